/* src/rcor_channel_regs.v */
`timescale 1ns/1ps
`include "rcor_consts.vh"

module rcor_channel_regs #(
  parameter DEFAULT_COUNT = 15'h0000,
  parameter LOW_RATE_RESET = 8'h00
) (
  // Clock and reset
  input wire clk_i,
  input wire resetn_i,
  input wire ce_i,
  // Register port from the serial management engine
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // Channel status from the analog and CDR logic
  input wire signal_detect_i,
  input wire cdr_locked_i,
  input wire [7:0] adaptive_boost_i,
  input wire [2:0] auto_div_code_i,
  // Measurement pins
  input wire ref_tick_pin_i,
  input wire vco_div32_pin_i,
  // Channel controls
  output reg [7:0] ctle_boost_o,
  output reg [3:0] div_ratio_o,
  output reg div_reserved_o,
  output reg out_mute_o,
  output reg out_sel_retimed_o,
  output reg [2:0] mux_override_o,
  output reg channel_power_o,
  output reg [14:0] measured_count_o,
  output reg freq_ok_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  reg [7:0] ctle_boost_override_value;
  reg [7:0] channel_override_control;
  reg [7:0] vco_divider_select;
  reg [7:0] output_mux_control;
  reg [7:0] ctle_override_enable;
  reg [7:0] low_rate_ctle_value;
  reg [7:0] ctle_applied_readback;
  reg [7:0] group1_count_low;
  reg [7:0] group1_count_high_override;
  reg [7:0] vco_tolerance_deltas;

  wire [14:0] meas_count;
  wire meas_done;
  reg [2:0] div_code;
  reg [3:0] next_ratio;
  reg [7:0] next_boost;
  reg [14:0] vco_target_count;
  reg [14:0] diff;
  wire manual_count_enable;
  wire [3:0] vco_count_tolerance;

  // Divider code to ratio; codes above 3 are reserved and fall back to 1
  function [3:0] rcor_div_ratio;
    input [2:0] code;
    begin
      case (code)
        3'd0: rcor_div_ratio = 4'd1;
        3'd1: rcor_div_ratio = 4'd2;
        3'd2: rcor_div_ratio = 4'd4;
        3'd3: rcor_div_ratio = 4'd8;
        default: rcor_div_ratio = 4'd1;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Frequency measurement

  // One-cycle done pulse marks the end of each reference window
  rcor_freq_meter #(
    .WINDOW(`RCOR_REF_WINDOW),
    .CW(15)
  ) u_meter (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .ref_tick_pin_i(ref_tick_pin_i),
    .vco_div32_pin_i(vco_div32_pin_i),
    .count_o(meas_count),
    .done_o(meas_done)
  );

  // Field views of the count and tolerance registers
  assign manual_count_enable = group1_count_high_override[`RCOR_BIT_MANUAL_COUNT];
  assign vco_count_tolerance = vco_tolerance_deltas[3:0];

  // Target selection and distance to the measured count
  always @* begin
    if (manual_count_enable) begin
      vco_target_count = {group1_count_high_override[6:0], group1_count_low};
    end else begin
      vco_target_count = DEFAULT_COUNT[14:0];
    end
    if (meas_count > vco_target_count) begin
      diff = meas_count - vco_target_count;
    end else begin
      diff = vco_target_count - meas_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider and CTLE selection

  always @* begin
    if (channel_override_control[`RCOR_BIT_DIV_OVR_EN]) begin
      div_code = vco_divider_select[`RCOR_DIV_FIELD_HI:`RCOR_DIV_FIELD_LO];
    end else begin
      div_code = auto_div_code_i;
    end
    next_ratio = rcor_div_ratio(div_code);
    if (ctle_override_enable[`RCOR_BIT_CTLE_OVR_EN]) begin
      next_boost = ctle_boost_override_value;
    end else if (next_ratio == 4'd4 || next_ratio == 4'd8) begin
      next_boost = low_rate_ctle_value;
    end else begin
      next_boost = adaptive_boost_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctle_boost_override_value <= `RCOR_RST_REG;
      channel_override_control <= `RCOR_RST_REG;
      vco_divider_select <= `RCOR_RST_REG;
      output_mux_control <= `RCOR_RST_OUT_MUX;
      ctle_override_enable <= `RCOR_RST_REG;
      low_rate_ctle_value <= LOW_RATE_RESET[7:0];
      group1_count_low <= `RCOR_RST_REG;
      group1_count_high_override <= `RCOR_RST_REG;
      vco_tolerance_deltas <= `RCOR_RST_REG;
    end else if (ce_i && reg_wr_i) begin
      // Values hold until rewritten; the readback register ignores writes
      case (reg_addr_i)
        `RCOR_ADDR_CTLE_OVR_VAL: ctle_boost_override_value <= reg_wdata_i;
        `RCOR_ADDR_CHAN_OVR_CTL: channel_override_control <= reg_wdata_i;
        `RCOR_ADDR_VCO_DIV_SEL: vco_divider_select <= reg_wdata_i;
        `RCOR_ADDR_OUT_MUX_CTL: output_mux_control <= reg_wdata_i;
        `RCOR_ADDR_CTLE_OVR_EN: ctle_override_enable <= reg_wdata_i;
        `RCOR_ADDR_LOW_RATE_CTLE: low_rate_ctle_value <= reg_wdata_i;
        `RCOR_ADDR_G1_COUNT_LOW: group1_count_low <= reg_wdata_i;
        `RCOR_ADDR_G1_COUNT_HIGH: group1_count_high_override <= reg_wdata_i;
        `RCOR_ADDR_TOL_DELTAS: vco_tolerance_deltas <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads, registered; unmapped offsets read zero

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (ce_i && reg_rd_i) begin
      // A read and a write in one cycle return the old value
      case (reg_addr_i)
        `RCOR_ADDR_CTLE_OVR_VAL: reg_rdata_o <= ctle_boost_override_value;
        `RCOR_ADDR_CHAN_OVR_CTL: reg_rdata_o <= channel_override_control;
        `RCOR_ADDR_VCO_DIV_SEL: reg_rdata_o <= vco_divider_select;
        `RCOR_ADDR_OUT_MUX_CTL: reg_rdata_o <= output_mux_control;
        `RCOR_ADDR_CTLE_OVR_EN: reg_rdata_o <= ctle_override_enable;
        `RCOR_ADDR_LOW_RATE_CTLE: reg_rdata_o <= low_rate_ctle_value;
        `RCOR_ADDR_CTLE_READBACK: reg_rdata_o <= ctle_applied_readback;
        `RCOR_ADDR_G1_COUNT_LOW: reg_rdata_o <= group1_count_low;
        `RCOR_ADDR_G1_COUNT_HIGH: reg_rdata_o <= group1_count_high_override;
        `RCOR_ADDR_TOL_DELTAS: reg_rdata_o <= vco_tolerance_deltas;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Applied settings and output control

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctle_applied_readback <= 8'h00;
      ctle_boost_o <= 8'h00;
      div_ratio_o <= 4'd1;
      div_reserved_o <= 1'b0;
      out_mute_o <= 1'b1;
      out_sel_retimed_o <= 1'b1;
      mux_override_o <= 3'b000;
      channel_power_o <= 1'b0;
      measured_count_o <= 15'h0000;
      freq_ok_o <= 1'b0;
    end else if (ce_i) begin
      // Readback mirrors the exact boost driven to the equalizer
      ctle_boost_o <= next_boost;
      ctle_applied_readback <= next_boost;
      div_ratio_o <= next_ratio;
      div_reserved_o <= div_code[2];
      // Muting follows status one cycle later; power tracks signal detect only
      channel_power_o <= signal_detect_i;
      out_mute_o <= !signal_detect_i || !cdr_locked_i;
      mux_override_o <= output_mux_control[`RCOR_MUX_FIELD_HI:`RCOR_MUX_FIELD_LO];
      if (channel_override_control[`RCOR_BIT_MUX_OVR_EN]) begin
        out_sel_retimed_o <= output_mux_control[`RCOR_BIT_OUT_SEL];
      end else begin
        out_sel_retimed_o <= 1'b1;
      end
      // Verdict moves only at window ends, so a read never sees half a result
      if (meas_done) begin
        measured_count_o <= meas_count;
        freq_ok_o <= (diff <= {11'h000, vco_count_tolerance});
      end
    end
  end

endmodule

/* src/rcor_consts.vh */
// Behaviour
// - The channel measures the VCO by counting VCO/32 edges over 1024 periods of the 25 MHz reference.
// - The programmed count is used only while the manual count enable bit of the high register is one.
// - With the CTLE override bit set, the boost from the override value register is applied.
// - The applied CTLE boost is always readable in a read-only register, adaptive or overridden.
// - With divide ratio 4 or 8 and the CTLE override bit clear, the CTLE does not adapt and the low-rate CTLE value is applied.
// - The output is muted without signal or without lock, and otherwise carries raw or retimed data.
// - Output select 1 routes retimed data (default when locked) and 0 routes raw equalizer data.
// - The output multiplexer override value is the three-bit field at bits 7:5 of the output register.
// - Without detected signal the channel, output driver included, is powered down and muted.
// - Divider field codes 0, 1, 2 and 3 select divide ratios 1, 2, 4 and 8.
// - The divider field replaces the automatic choice only while bit 2 of the control register is set.
`ifndef RCOR_CONSTS_VH
`define RCOR_CONSTS_VH

// Register offsets
`define RCOR_ADDR_CTLE_OVR_VAL 8'h03
`define RCOR_ADDR_CHAN_OVR_CTL 8'h09
`define RCOR_ADDR_VCO_DIV_SEL 8'h18
`define RCOR_ADDR_OUT_MUX_CTL 8'h1e
`define RCOR_ADDR_CTLE_OVR_EN 8'h2d
`define RCOR_ADDR_LOW_RATE_CTLE 8'h3a
`define RCOR_ADDR_CTLE_READBACK 8'h52
`define RCOR_ADDR_G1_COUNT_LOW 8'h62
`define RCOR_ADDR_G1_COUNT_HIGH 8'h63
`define RCOR_ADDR_TOL_DELTAS 8'h64

// Field positions
`define RCOR_BIT_DIV_OVR_EN 2
`define RCOR_BIT_MUX_OVR_EN 5
`define RCOR_BIT_CTLE_OVR_EN 3
`define RCOR_BIT_MANUAL_COUNT 7
`define RCOR_BIT_OUT_SEL 7
`define RCOR_DIV_FIELD_HI 6
`define RCOR_DIV_FIELD_LO 4
`define RCOR_MUX_FIELD_HI 7
`define RCOR_MUX_FIELD_LO 5

// Reset values
`define RCOR_RST_REG 8'h00
`define RCOR_RST_OUT_MUX 8'h80

// Measurement constants
`define RCOR_REF_FREQ_MHZ 25
`define RCOR_REF_WINDOW 1024
`define RCOR_VCO_PRESCALE 32

`endif

/* src/rcor_freq_meter.v */
`timescale 1ns/1ps
`include "rcor_consts.vh"

module rcor_freq_meter #(
  parameter WINDOW = `RCOR_REF_WINDOW,
  parameter CW = 15
) (
  // Clock and reset
  input wire clk_i,
  input wire resetn_i,
  input wire ce_i,
  // Pins from outside the clock domain
  input wire ref_tick_pin_i,
  input wire vco_div32_pin_i,
  // Result
  output reg [CW-1:0] count_o,
  output reg done_o
);

  reg [2:0] ref_sync;
  reg [2:0] vco_sync;
  reg ref_stable;
  reg vco_stable;
  reg [10:0] ref_cnt;
  reg [CW-1:0] vco_cnt;
  wire ref_rise;
  wire vco_rise;

  // A rise counts once the second and third stages agree
  assign ref_rise = (ref_sync[1] == ref_sync[2]) && ref_sync[2] && !ref_stable;
  assign vco_rise = (vco_sync[1] == vco_sync[2]) && vco_sync[2] && !vco_stable;

  // Synchronise, then count VCO/32 edges over the reference window
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_sync <= 3'b000;
      vco_sync <= 3'b000;
      ref_stable <= 1'b0;
      vco_stable <= 1'b0;
      ref_cnt <= 11'h000;
      vco_cnt <= {CW{1'b0}};
      count_o <= {CW{1'b0}};
      done_o <= 1'b0;
    end else if (ce_i) begin
      ref_sync <= {ref_sync[1:0], ref_tick_pin_i};
      vco_sync <= {vco_sync[1:0], vco_div32_pin_i};
      if (ref_sync[1] == ref_sync[2]) ref_stable <= ref_sync[2];
      if (vco_sync[1] == vco_sync[2]) vco_stable <= vco_sync[2];
      done_o <= 1'b0;
      if (ref_rise && (ref_cnt == WINDOW[10:0] - 11'h001)) begin
        count_o <= vco_cnt + {{(CW-1){1'b0}}, vco_rise && (vco_cnt != {CW{1'b1}})};
        done_o <= 1'b1;
        ref_cnt <= 11'h000;
        vco_cnt <= {CW{1'b0}};
      end else begin
        if (ref_rise) ref_cnt <= ref_cnt + 11'h001;
        if (vco_rise && (vco_cnt != {CW{1'b1}})) vco_cnt <= vco_cnt + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

/* testbench/rcor_regs_checker.sv */
`timescale 1ns/1ps
module rcor_regs_checker (
  // Clock, reset and register port
  input wire clk_i,
  input wire resetn_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  // Channel status and controls
  input wire signal_detect_i,
  input wire cdr_locked_i,
  input wire [7:0] ctle_boost_o,
  input wire [3:0] div_ratio_o,
  input wire div_reserved_o,
  input wire out_mute_o,
  input wire [2:0] mux_override_o,
  input wire channel_power_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // Output and power follow the channel status
  AST_DARK_NO_SIGNAL: assert property (!signal_detect_i |=> out_mute_o && !channel_power_o)
    else $error("channel live without signal");
  AST_MUTE_NO_LOCK: assert property (!cdr_locked_i |=> out_mute_o)
    else $error("output live without lock");
  AST_LIVE_LOCKED: assert property (signal_detect_i && cdr_locked_i |=> !out_mute_o)
    else $error("output muted while locked");
  // Divider decode
  AST_RATIO_SET: assert property (div_ratio_o inside {4'h1, 4'h2, 4'h4, 4'h8})
    else $error("ratio outside decode");
  AST_RESERVED_ONE: assert property (div_reserved_o |-> div_ratio_o == 4'h1)
    else $error("reserved code without fallback");
  // Register port answers
  AST_READBACK: assert property (reg_rd_i && reg_addr_i == 8'h52 |=>
    reg_rdata_o == $past(ctle_boost_o)) else $error("readback differs from boost");
  AST_RDATA_HOLDS: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without read");
  AST_MUX_FIELD: assert property (reg_wr_i && reg_addr_i == 8'h1e |=> ##1
    mux_override_o == $past(reg_wdata_i[7:5], 2)) else $error("mux field not taken");
endmodule
bind rcor_channel_regs rcor_regs_checker u_chk (
  .clk_i(clk_i),
  .resetn_i(resetn_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .signal_detect_i(signal_detect_i),
  .cdr_locked_i(cdr_locked_i),
  .ctle_boost_o(ctle_boost_o),
  .div_ratio_o(div_ratio_o),
  .div_reserved_o(div_reserved_o),
  .out_mute_o(out_mute_o),
  .mux_override_o(mux_override_o),
  .channel_power_o(channel_power_o)
);

/* testbench/rcor_ctrl_model.sv */
`timescale 1ns/1ps
module rcor_ctrl_model (
  // Clock
  input wire clk_i,
  // Register port toward the channel
  output reg [7:0] reg_addr_o,
  output reg [7:0] reg_wdata_o,
  output reg reg_wr_o,
  output reg reg_rd_o,
  input wire [7:0] reg_rdata_i
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // One write strobe; released lines show inverted values, not stale ones
  task automatic write_reg(input [7:0] a, input [7:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask
  // One read strobe; data taken a cycle and a half after the read edge
  task automatic read_reg(input [7:0] a, output [7:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge clk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    @(negedge clk_i);
    d = reg_rdata_i;
  endtask
  // Target count and tolerance for a VCO rate, enable written last
  task automatic program_count(input real vco_ghz);
    int cnt;
    int tol;
    cnt = $rtoi(vco_ghz * 1.0e9 / 32.0 * 1024.0 / 25.0e6 + 0.5);
    tol = (cnt / 1000 > 15) ? 15 : cnt / 1000;
    write_reg(8'h62, cnt[7:0]);
    write_reg(8'h64, {4'h0, tol[3:0]});
    write_reg(8'h63, {1'b1, cnt[14:8]});
  endtask
endmodule

/* testbench/retimer_channel_override_regs_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module retimer_channel_override_regs_tb;
  logic clk_i = 0, resetn_i = 0, sd = 0, lock = 0, ref_pin = 0, vco_pin = 0, ce = 1;
  logic [7:0] boost = 0, rd, v;
  logic [2:0] acode = 0;
  logic [7:0] ra[10] = '{8'h03, 8'h09, 8'h18, 8'h1e, 8'h2d, 8'h3a, 8'h62, 8'h63, 8'h64, 8'h70};
  wire [7:0] addr, wdata, rdata, ctle;
  wire wr, rdst, res, mute, sel, pwr, fok;
  wire [3:0] ratio;
  wire [2:0] mux;
  wire [14:0] meas;
  int failures = 0, total_checks = 0, n;
  // Clock and measurement pins, vco edges aligned with ref edges
  initial forever #12.5 clk_i = ~clk_i;
  initial #3 forever #50 ref_pin = ~ref_pin;
  initial #103 forever #100 vco_pin = ~vco_pin;
  rcor_channel_regs u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rdst), .reg_rdata_o(rdata),
    .signal_detect_i(sd), .cdr_locked_i(lock), .adaptive_boost_i(boost), .auto_div_code_i(acode),
    .ref_tick_pin_i(ref_pin), .vco_div32_pin_i(vco_pin), .ctle_boost_o(ctle), .div_ratio_o(ratio),
    .div_reserved_o(res), .out_mute_o(mute), .out_sel_retimed_o(sel), .mux_override_o(mux),
    .channel_power_o(pwr), .measured_count_o(meas), .freq_ok_o(fok));
  rcor_ctrl_model u_ctrl (.clk_i(clk_i), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
    .reg_rd_o(rdst), .reg_rdata_i(rdata));
  task automatic settle;
    repeat (2) @(negedge clk_i);
  endtask
  task automatic rd_chk(input string nm, input [7:0] a, input [7:0] e);
    u_ctrl.read_reg(a, rd);
    `CHK(nm, e, rd)
  endtask
  // Bounded wait for a full window with the given verdict
  task automatic wait_meas(input logic ok);
    n = 0;
    while (!(meas === 15'd512 && fok === ok) && n < 12000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 12000) begin
      failures++;
      $display("unexpected timeout on window verdict");
      wrap_up();
    end
    `CHK("window count", 15'd512, meas)
    `CHK("window verdict", ok, fok)
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h84b02ce9));
    repeat (10) @(negedge clk_i);
    `CHK("reset mute", 1'b1, mute)
    `CHK("reset ratio", 4'h1, ratio)
    resetn_i = 1;
    foreach (ra[i]) rd_chk("reset", ra[i], (ra[i] == 8'h1e) ? 8'h80 : 8'h00);
    $display("reset test done");
    sd = 1;
    lock = 1;
    for (int i = 0; i < 4; i++) begin
      boost = $urandom;
      v = $urandom;
      u_ctrl.write_reg(8'h52, ~boost);
      settle();
      `CHK("adaptive", boost, ctle)
      rd_chk("readback", 8'h52, boost);
      u_ctrl.write_reg(8'h03, v);
      u_ctrl.write_reg(8'h2d, 8'h08);
      settle();
      `CHK("override", v, ctle)
      rd_chk("readback", 8'h52, v);
      v = (i == 3) ? 8'h00 : ~v;
      u_ctrl.write_reg(8'h2d, 8'h00);
      u_ctrl.write_reg(8'h3a, v);
      acode = 3'd2 + i[0];
      settle();
      `CHK("low rate", v, ctle)
      acode = 0;
    end
    $display("ctle test done");
    u_ctrl.write_reg(8'h03, 8'h3c);
    ce = 0;
    boost = ~boost;
    u_ctrl.write_reg(8'h03, 8'hc3);
    settle();
    `CHK("frozen boost", ~boost, ctle)
    ce = 1;
    rd_chk("frozen reg", 8'h03, 8'h3c);
    $display("enable test done");
    u_ctrl.write_reg(8'h09, 8'h04);
    acode = 3'd3;
    for (int c = 0; c < 8; c++) begin
      u_ctrl.write_reg(8'h18, {1'b0, c[2:0], 4'h0});
      settle();
      `CHK("ratio", (c < 4) ? 4'h1 << c : 4'h1, ratio)
      `CHK("reserved", c > 3, res)
    end
    u_ctrl.write_reg(8'h09, 8'h20);
    settle();
    `CHK("auto ratio", 4'h8, ratio)
    $display("divider test done");
    for (int k = 0; k < 8; k++) begin
      sd = k[0];
      lock = k[1];
      v = $urandom;
      v[7] = k[2];
      u_ctrl.write_reg(8'h1e, v);
      settle();
      `CHK("mute", !(sd && lock), mute)
      `CHK("power", sd, pwr)
      `CHK("mux field", v[7:5], mux)
      if (sd && lock) `CHK("select", k[2], sel)
    end
    u_ctrl.write_reg(8'h09, 8'h00);
    settle();
    `CHK("default select", 1'b1, sel)
    $display("output test done");
    u_ctrl.write_reg(8'h62, 8'h00);
    u_ctrl.write_reg(8'h63, 8'h02);
    wait_meas(1'b0);
    u_ctrl.program_count(0.4);
    wait_meas(1'b1);
    u_ctrl.program_count(0.41);
    wait_meas(1'b0);
    u_ctrl.program_count(10.3125);
    rd_chk("count low", 8'h62, 8'h90);
    rd_chk("count high", 8'h63, 8'hb3);
    rd_chk("tolerance", 8'h64, 8'h0d);
    $display("measure test done");
    wrap_up();
  end
endmodule
